// ### hdl/mlfr_ms_tick.sv
// One-millisecond enable pulse divider
`timescale 1ns/10ps
module mlfr_ms_tick
  import mlfr_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
)
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  output logic      msTick
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        tick_nxt;

  // Count cycles, pulse once per ms
  always_comb
  begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + 32'd1;
    if (cnt_r >= 32'(MS_CYC - 1))
    begin
      cnt_nxt  = 32'd0;
      tick_nxt = 1'b1;
    end
  end

  // Register divider
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r  <= 32'd0;
      msTick <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      msTick <= tick_nxt;
    end
  end

endmodule

// ### hdl/mlfr_pkg.sv
// Constants and types for the motor lock fault response block
//////////////////////////////////////////////////////////////////////
// Overview of operation
// R1: Retry delay 300ms, 500ms, then 1-14 s.
// R2: Codes 0h/1h latch fault and tristate drivers.
// R3: Code 2h latches fault, high-side brake.
// R4: Code 3h latches fault, low-side brake.
// R5: Codes 4h/5h tristate, auto-clear, latch past limit.
// R6: Code 6h high-side brake with limited retries.
// R7: Code 7h low-side brake with limited retries.
// R8: Code 8h only reports the lock fault.
// R9: Codes 9h, Ah, Ch disable lock detection.
// R10: Position-detect timeout fault only when enabled.
// R11: Retry counter counts clears, compared to limit.
//////////////////////////////////////////////////////////////////////
package mlfr_pkg;

  // Clock rate and time base
  localparam int          CLK_MHZ         = 250;
  localparam int          MS_NS           = 1000000;
  localparam int          MS_CYCLES       = MS_NS * CLK_MHZ / 1000;

  // Retry delay figures in ms
  localparam logic [13:0] RETRY_MS_CODE0  = 14'd300;
  localparam logic [13:0] RETRY_MS_CODE1  = 14'd500;
  localparam logic [13:0] RETRY_MS_STEP   = 14'd1000;

  // Register byte addresses
  localparam logic [7:0]  ADDR_CONFIG     = 8'h00;
  localparam logic [7:0]  ADDR_CTRL       = 8'h04;
  localparam logic [7:0]  ADDR_STATUS     = 8'h08;
  localparam logic [7:0]  ADDR_MASK       = 8'h0c;
  localparam logic [7:0]  ADDR_STATE      = 8'h10;

  // Config field positions
  localparam int          DELAY_LSB       = 7;
  localparam int          RESP_LSB        = 3;
  localparam int          IPD_EN_BIT      = 2;
  // Control field positions
  localparam int          LIMIT_LSB       = 0;
  localparam int          CLEAR_BIT       = 8;

  // Reset values
  localparam logic [3:0]  DELAY_RST       = 4'h0;
  localparam logic [3:0]  RESP_RST        = 4'h0;
  localparam logic        IPD_EN_RST      = 1'b0;
  localparam logic [2:0]  LIMIT_RST       = 3'h0;
  localparam logic [3:0]  MASK_RST        = 4'h0;

  // Status bit positions
  localparam int          ST_LOCK         = 0;
  localparam int          ST_LATCH        = 1;
  localparam int          ST_IPD          = 2;
  localparam int          ST_RETRY        = 3;

  typedef enum logic [1:0] {MLFR_IDLE, MLFR_RETRY, MLFR_LATCHED} mlfr_state_t;

  // Decode of the retry delay field into ms
  function automatic logic [13:0] retryDelayMs(input logic [3:0] code);
    logic [13:0] ms;
    ms = 14'd0;
    case (code)
      4'h0:    ms = RETRY_MS_CODE0;
      4'h1:    ms = RETRY_MS_CODE1;
      default: ms = 14'(({10'd0, code} - 14'd1) * RETRY_MS_STEP);
    endcase
    return ms;
  endfunction

endpackage

// ### hdl/mlfr_retry_timer.sv
// Retry delay timer counting ms ticks
`timescale 1ns/10ps
module mlfr_retry_timer
  import mlfr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [3:0] delayCode,
  input  wire logic       msTick,
  output logic            done
);

  logic [13:0] left_r;
  logic [13:0] left_nxt;
  logic        run_r;
  logic        run_nxt;
  logic        done_nxt;

  // Load on start, count down per tick
  always_comb
  begin
    left_nxt = left_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (abort)
      run_nxt = 1'b0;
    else if (start)
    begin
      left_nxt = retryDelayMs(delayCode); // [R1]
      run_nxt  = 1'b1;
    end
    else if (run_r && msTick)
    begin
      left_nxt = left_r - 14'd1;
      if (left_r <= 14'd1)
      begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  // Register timer
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      left_r <= 14'd0;
      run_r  <= 1'b0;
      done   <= 1'b0;
    end
    else
    begin
      left_r <= left_nxt;
      run_r  <= run_nxt;
      done   <= done_nxt;
    end
  end

endmodule

// ### hdl/mlfr_top.sv
// Motor lock fault response with APB registers and interrupt
`timescale 1ns/10ps
module mlfr_top
  import mlfr_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
)
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lockDetect,
  input  wire logic        ipdTimeout,
  output logic             faultIndicatorLow,
  output logic             gateTristate,
  output logic             highSideBrake,
  output logic             lowSideBrake,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////
  // Declarations
  logic [3:0]  delay_r;
  logic [3:0]  delay_nxt;
  logic [3:0]  resp_r;
  logic [3:0]  resp_nxt;
  logic        ipdEn_r;
  logic        ipdEn_nxt;
  logic [2:0]  limit_r;
  logic [2:0]  limit_nxt;
  logic [3:0]  status_r;
  logic [3:0]  status_nxt;
  logic [3:0]  mask_r;
  logic [3:0]  mask_nxt;
  logic [31:0] rdata_nxt;
  logic        ready_nxt;
  logic        err_nxt;
  logic        setup;
  logic        wrAcc;
  logic        mapped;
  logic        clearCmd;
  mlfr_state_t state_r;
  mlfr_state_t state_nxt;
  logic [3:0]  action_r;
  logic [3:0]  action_nxt;
  logic [2:0]  retryCnt_r;
  logic [2:0]  retryCnt_nxt;
  logic        ipdFault_r;
  logic        ipdFault_nxt;
  logic        lockPrev_r;
  logic        lockRise;
  logic        lockEnabled;
  logic        retryMode;
  logic        reportOnly;
  logic        timerStart;
  logic        timerDone;
  logic        msTick;
  logic        evLock;
  logic        evLatch;
  logic        evRetry;
  logic        evIpd;
  logic        fault_indicator_low_nxt;
  logic        tri_nxt;
  logic        hs_nxt;
  logic        ls_nxt;

  //////////////////////////////////////////////////////////////////////
  // Time base and retry delay
  mlfr_ms_tick #(
    .MS_CYC (MS_CYC)
  ) uTick (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .msTick  (msTick)
  );

  mlfr_retry_timer uTimer (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .start     (timerStart),
    .abort     (clearCmd),
    .delayCode (delay_r),
    .msTick    (msTick),
    .done      (timerDone)
  );

  //////////////////////////////////////////////////////////////////////
  // APB decode
  assign setup    = psel && !penable;
  assign wrAcc    = psel && penable && pwrite && pready;
  assign mapped   = (paddr == ADDR_CONFIG) || (paddr == ADDR_CTRL) ||
                    (paddr == ADDR_STATUS) || (paddr == ADDR_MASK) ||
                    (paddr == ADDR_STATE);
  assign clearCmd = wrAcc && (paddr == ADDR_CTRL) && pwdata[CLEAR_BIT];

  // Read data, ready and error prepared in the setup cycle
  always_comb
  begin
    rdata_nxt = 32'h0;
    ready_nxt = setup;
    err_nxt   = setup && !mapped;
    if (setup && !pwrite)
    begin
      case (paddr)
        ADDR_CONFIG: rdata_nxt = {21'h0, delay_r, resp_r, ipdEn_r, 2'h0};
        ADDR_CTRL:   rdata_nxt = {29'h0, limit_r};
        ADDR_STATUS: rdata_nxt = {28'h0, status_r};
        ADDR_MASK:   rdata_nxt = {28'h0, mask_r};
        ADDR_STATE:  rdata_nxt = {20'h0, action_r, 1'b0, retryCnt_r,
                                  ipdFault_r, 1'b0, 2'(state_r)};
        default:     rdata_nxt = 32'h0;
      endcase
    end
  end

  // Register bus answer
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= rdata_nxt;
      pready  <= ready_nxt;
      pslverr <= err_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Software registers
  always_comb
  begin
    delay_nxt = delay_r;
    resp_nxt  = resp_r;
    ipdEn_nxt = ipdEn_r;
    limit_nxt = limit_r;
    mask_nxt  = mask_r;
    if (wrAcc)
    begin
      case (paddr)
        ADDR_CONFIG:
        begin
          delay_nxt = pwdata[DELAY_LSB +: 4];
          resp_nxt  = pwdata[RESP_LSB +: 4];
          ipdEn_nxt = pwdata[IPD_EN_BIT];
        end
        ADDR_CTRL:   limit_nxt = pwdata[LIMIT_LSB +: 3];
        ADDR_MASK:   mask_nxt  = pwdata[3:0];
        default:     mask_nxt  = mask_r;
      endcase
    end
  end

  // Status bits: a new event wins over a write-one clear
  always_comb
  begin
    status_nxt = status_r;
    if (wrAcc && (paddr == ADDR_STATUS))
      status_nxt = status_r & ~pwdata[3:0];
    status_nxt = status_nxt | {evRetry, evIpd, evLatch, evLock};
  end

  // Register software state
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      delay_r  <= DELAY_RST;
      resp_r   <= RESP_RST;
      ipdEn_r  <= IPD_EN_RST; // [R10]
      limit_r  <= LIMIT_RST;
      mask_r   <= MASK_RST;
      status_r <= 4'h0;
    end
    else
    begin
      delay_r  <= delay_nxt;
      resp_r   <= resp_nxt;
      ipdEn_r  <= ipdEn_nxt;
      limit_r  <= limit_nxt;
      mask_r   <= mask_nxt;
      status_r <= status_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Response mode decode
  // Codes Bh, Dh, Eh and Fh fall in the disabled group
  assign lockEnabled = (resp_r <= 4'h8);                      // [R9]
  assign reportOnly  = (resp_r == 4'h8);                      // [R8]
  assign retryMode   = (resp_r >= 4'h4) && (resp_r <= 4'h7);
  assign lockRise    = lockDetect && !lockPrev_r && lockEnabled;

  // Lock fault sequencer
  always_comb
  begin
    state_nxt    = state_r;
    action_nxt   = action_r;
    retryCnt_nxt = retryCnt_r;
    timerStart   = 1'b0;
    evLock       = 1'b0;
    evLatch      = 1'b0;
    evRetry      = 1'b0;
    case (state_r)
      MLFR_IDLE:
      begin
        if (lockRise)
        begin
          evLock     = 1'b1;
          action_nxt = resp_r;
          if (reportOnly)
            state_nxt = MLFR_IDLE;
          else if (!retryMode)
          begin
            state_nxt = MLFR_LATCHED; // [R2] [R3] [R4]
            evLatch   = 1'b1;
          end
          // Retries used up: hold the fault until software clears it
          else if (retryCnt_r >= limit_r)
          begin
            state_nxt = MLFR_LATCHED; // [R5] [R6] [R7]
            evLatch   = 1'b1;
          end
          else
          begin
            state_nxt  = MLFR_RETRY;
            timerStart = 1'b1; // [R1]
          end
        end
      end
      MLFR_RETRY:
      begin
        if (clearCmd)
          state_nxt = MLFR_IDLE;
        else if (timerDone)
        begin
          state_nxt    = MLFR_IDLE; // [R5] [R6] [R7]
          retryCnt_nxt = retryCnt_r + 3'd1; // [R11]
          evRetry      = 1'b1;
        end
      end
      MLFR_LATCHED:
      begin
        if (clearCmd)
          state_nxt = MLFR_IDLE;
      end
      default:
        state_nxt = MLFR_IDLE;
    endcase
  end

  // Position-detect timeout fault
  always_comb
  begin
    evIpd        = ipdTimeout && ipdEn_r; // [R10]
    ipdFault_nxt = ipdFault_r;
    if (clearCmd)
      ipdFault_nxt = 1'b0;
    if (evIpd)
      ipdFault_nxt = 1'b1;
  end

  // Register sequencer state
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r    <= MLFR_IDLE;
      action_r   <= 4'h0;
      retryCnt_r <= 3'h0; // [R11]
      ipdFault_r <= 1'b0;
      lockPrev_r <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      action_r   <= action_nxt;
      retryCnt_r <= retryCnt_nxt;
      ipdFault_r <= ipdFault_nxt;
      lockPrev_r <= lockDetect;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Driver actions and fault indicator
  always_comb
  begin
    tri_nxt    = 1'b0;
    hs_nxt     = 1'b0;
    ls_nxt     = 1'b0;
    fault_indicator_low_nxt = 1'b1;
    if (state_nxt != MLFR_IDLE)
    begin
      fault_indicator_low_nxt = 1'b0;
      case (action_nxt)
        4'h0, 4'h1, 4'h4, 4'h5: tri_nxt = 1'b1; // [R2] [R5]
        4'h2, 4'h6:             hs_nxt  = 1'b1; // [R3] [R6]
        4'h3, 4'h7:             ls_nxt  = 1'b1; // [R4] [R7]
        default:                tri_nxt = 1'b0;
      endcase
    end
    // Report-only and position faults pull only the indicator
    if (reportOnly && lockDetect)
      fault_indicator_low_nxt = 1'b0; // [R8]
    if (ipdFault_nxt)
      fault_indicator_low_nxt = 1'b0; // [R10]
  end

  // Register outputs and interrupt
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      faultIndicatorLow <= 1'b1;
      gateTristate      <= 1'b0;
      highSideBrake     <= 1'b0;
      lowSideBrake      <= 1'b0;
      irq               <= 1'b0;
    end
    else
    begin
      faultIndicatorLow <= fault_indicator_low_nxt;
      gateTristate      <= tri_nxt;
      highSideBrake     <= hs_nxt;
      lowSideBrake      <= ls_nxt;
      irq               <= |(status_nxt & mask_r);
    end
  end

endmodule

// ### verif/mlfr_monitor.sv
// Port checks for the motor lock fault response block
`timescale 1ns/10ps
module mlfr_monitor
(
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        lockDetect,
  input wire logic        ipdTimeout,
  input wire logic        faultIndicatorLow,
  input wire logic        gateTristate,
  input wire logic        highSideBrake,
  input wire logic        lowSideBrake
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////
  // Bus phases
  sequence apbSetup;
    psel && !penable;
  endsequence
  sequence apbAccess;
    psel && penable && pready;
  endsequence
  // Answer one cycle after setup, standing one cycle
  apb_answer_a: assert property (apbSetup |=> apbAccess ##1 !pready)
    else $error("bus answer late or held");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  //////////////////////////////////////////////////////////////////////
  // Gate actions and fault indicator
  drive_onehot_a: assert property (
    $onehot0({gateTristate, highSideBrake, lowSideBrake}))
    else $error("two gate actions at once");
  drive_fault_a: assert property (
    (gateTristate || highSideBrake || lowSideBrake) |-> !faultIndicatorLow)
    else $error("gate action without fault");
  fault_cause_a: assert property (
    $fell(faultIndicatorLow) |-> $past(lockDetect) || $past(ipdTimeout))
    else $error("fault without cause");
  drive_cause_a: assert property (
    $rose(gateTristate || highSideBrake || lowSideBrake) |-> $past(lockDetect))
    else $error("gate action without lock");
endmodule
bind mlfr_top mlfr_monitor u_mon (.*);

// ### verif/mlfr_test.sv
// Self-checking bench for the motor lock fault response block
`timescale 1ns/10ps
module mlfr_test import mlfr_pkg::*;;
  localparam int MSC = 4;
  logic        sys_clk, nrst, psel, penable, pwrite, lockDetect, ipdTimeout, lastErr;
  logic        pready, pslverr, faultIndicatorLow, gateTristate, highSideBrake, lowSideBrake, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdVal;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  mlfr_top #(.MS_CYC(MSC)) DUT (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lockDetect(lockDetect), .ipdTimeout(ipdTimeout),
    .faultIndicatorLow(faultIndicatorLow), .gateTristate(gateTristate),
    .highSideBrake(highSideBrake), .lowSideBrake(lowSideBrake), .irq(irq));
  //////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Setup, then access held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdVal   = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rdVal);
  endtask
  function automatic logic [31:0] outs();
    return {28'h0, faultIndicatorLow, gateTristate, highSideBrake, lowSideBrake};
  endfunction
  function automatic logic [31:0] cfg(input logic [3:0] dl, input logic [3:0] rs, input logic ip);
    return {21'h0, dl, rs, ip, 2'b0};
  endfunction
  task automatic lockSet(input logic v);
    @(posedge sys_clk);
    lockDetect <= v;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic ipdPulse();
    @(posedge sys_clk);
    ipdTimeout <= 1'b1;
    @(posedge sys_clk);
    ipdTimeout <= 1'b0;
    @(negedge sys_clk);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic regTest();
    rd(ADDR_CONFIG, 32'h0, "config reset");
    rd(ADDR_MASK, 32'h0, "mask reset");
    xfer(1'b1, ADDR_CONFIG, 32'hffffffff);
    rd(ADDR_CONFIG, 32'h7fc, "config rw");
    rd(8'h20, 32'h0, "unmapped read");
    chk("unmapped err", 32'h1, {31'h0, lastErr});
  endtask
  task automatic latchTest();
    for (int c = 0; c < 4; c++)
    begin
      xfer(1'b1, ADDR_CONFIG, cfg(4'h0, 4'(c), 1'b0));
      lockSet(1'b1);
      lockSet(1'b0);
      repeat (1300) @(negedge sys_clk);
      chk("latched drive", (c < 2) ? 32'h4 : (c == 2) ? 32'h2 : 32'h1, outs());
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk("latch status", 32'h3, rdVal & 32'h3);
      xfer(1'b1, ADDR_CTRL, 32'h100);
      repeat (2) @(negedge sys_clk);
      chk("latch cleared", 32'h8, outs());
    end
  endtask
  task automatic retryTest();
    logic [3:0]  dl[4] = '{4'h0, 4'h1, 4'h2, 4'hf};
    logic [31:0] e;
    int          expCyc, n;
    for (int i = 0; i < 4; i++)
    begin
      e = (i < 2) ? 32'h4 : (i == 2) ? 32'h2 : 32'h1;
      expCyc = MSC * ((dl[i] == 0) ? 300 : (dl[i] == 1) ? 500 : (dl[i] - 1) * 1000);
      xfer(1'b1, ADDR_CTRL, 32'(i + 1));
      xfer(1'b1, ADDR_CONFIG, cfg(dl[i], 4'(4 + i), 1'b0));
      lockSet(1'b1);
      chk("retry drive", e, outs());
      lockSet(1'b0);
      n = 2;
      while (faultIndicatorLow !== 1'b1 && n < expCyc + 20)
      begin
        @(negedge sys_clk);
        n++;
      end
      samples_checked++;
      if (n < expCyc - 2 * MSC || n > expCyc + 2 * MSC)
      begin
        miscompares++;
        $display("mismatch retry delay expected %0d seen %0d", expCyc, n);
      end
      chk("retry release", 32'h8, outs());
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk("retry status", 32'h8, rdVal & 32'h8);
      xfer(1'b0, ADDR_STATE, 32'h0);
      chk("retry count", 32'(i + 1), (rdVal >> 4) & 32'h7);
      lockSet(1'b1);
      lockSet(1'b0);
      repeat (2100) @(negedge sys_clk);
      chk("retry latched", e, outs());
      xfer(1'b1, ADDR_CTRL, 32'h100);
      xfer(1'b1, ADDR_STATUS, 32'hf);
    end
  endtask
  task automatic modeTest();
    logic [3:0] off[3] = '{4'h9, 4'ha, 4'hc};
    xfer(1'b1, ADDR_CONFIG, cfg(4'h0, 4'h8, 1'b0));
    lockSet(1'b1);
    chk("report drive", 32'h0, outs());
    lockSet(1'b0);
    chk("report release", 32'h8, outs());
    for (int i = 0; i < 3; i++)
    begin
      xfer(1'b1, ADDR_CONFIG, cfg(4'h0, off[i], 1'b0));
      lockSet(1'b1);
      chk("disabled lock", 32'h8, outs());
      lockSet(1'b0);
    end
    ipdPulse();
    chk("ipd disabled", 32'h8, outs());
    xfer(1'b1, ADDR_CONFIG, cfg(4'h0, 4'h9, 1'b1));
    ipdPulse();
    chk("ipd enabled", 32'h0, outs());
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("ipd status", 32'h4, rdVal & 32'h4);
    xfer(1'b1, ADDR_CTRL, 32'h100);
    repeat (2) @(negedge sys_clk);
    chk("ipd cleared", 32'h8, outs());
  endtask
  task automatic irqTest();
    xfer(1'b1, ADDR_STATUS, 32'hf);
    xfer(1'b1, ADDR_MASK, 32'h1);
    xfer(1'b1, ADDR_CONFIG, cfg(4'h0, 4'h8, 1'b0));
    lockSet(1'b1);
    @(negedge sys_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    lockSet(1'b0);
    xfer(1'b1, ADDR_MASK, 32'h0);
    repeat (2) @(negedge sys_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    xfer(1'b1, ADDR_MASK, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    xfer(1'b1, ADDR_STATUS, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask
  task automatic test_done();
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 95000)
    begin
      miscompares++;
      test_done();
    end
  end
  initial
  begin
    {nrst, psel, penable, pwrite, lockDetect, ipdTimeout} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    regTest();
    latchTest();
    retryTest();
    modeTest();
    irqTest();
    test_done();
  end
endmodule
